// ### common/cmd_link_if.sv
// Command/address link between controller and device
interface cmd_link_if;
    logic cs_n;
    logic [23:0] ca;
    logic par;
    logic alert_n;
    logic clk_valid;
    logic cke;
    logic test_enable_input;
    modport device (input cs_n, input ca, input par, input clk_valid, input cke, input test_enable_input,
        output alert_n);
    modport host (output cs_n, output ca, output par, output clk_valid, output cke, output test_enable_input,
        input alert_n);
endinterface

// ### common/cmd_timing_consts.svh
// Timing counts and bus width shared by both ends
`ifndef CMD_TIMING_CONSTS_SVH
`define CMD_TIMING_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define CA_WIDTH 24
`define PAR_LAT_1600 4
`define PAR_LAT_2400 5
`define ALERT_ON_EXTRA_NS 6
`define ALERT_ON_EXTRA_CYC ((`ALERT_ON_EXTRA_NS) / (`CLK_PERIOD_NS) < 1 ? 1 : (`ALERT_ON_EXTRA_NS) / (`CLK_PERIOD_NS))
`define ALERT_PW_MIN_1600 48
`define ALERT_PW_MIN_1866 56
`define ALERT_PW_MIN_2133 64
`define ALERT_PW_MIN_2400 72
`define RSP_1600 43
`define RSP_1866 50
`define RSP_2133 57
`define RSP_2400 64
`define CAL_1600 3
`define CAL_1866 4
`define CAL_2400 5
`define MOD_MIN_CK 24
`define CPDED_MIN_CK 4
`define CKSRX_MIN_CK 10
`define XS_MIN_CK 30
`define XSDLL_MIN_CK 64
`define CT_ENABLE_NS 200
`define CT_ENABLE_CYC (((`CT_ENABLE_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`endif

// ### common/cmd_timing_pkg.sv
// Types shared by both ends of the command path
package cmd_timing_pkg;
    typedef enum logic [1:0] {
        GRADE_1600,
        GRADE_1866,
        GRADE_2133,
        GRADE_2400
    } speed_grade_e;
    typedef enum logic [2:0] {
        CMD_DESELECT,
        CMD_MODE_REG,
        CMD_DLL_FREE,
        CMD_DLL_LOCKED,
        CMD_MAX_POWER_SAVING_MODE_ENTER,
        CMD_OTHER
    } cmd_kind_e;
endpackage

// ### src/dram_cmd_device.sv
// Device end: parity check, alert pulse, latency and power saving timing
// Summary of operation
// - Parity latency 4, or 5 at 2400
// - Alert asserts within latency plus 6 ns
// - Alert low width bounded per speed grade
// - Controller sends deselects within response window
// - Command sampled fixed cycles after chip select
// - Latency mode never combined with gear-down
// - Command path off after update plus disable
// - Controller keeps clock after power saving entry
// - Controller gives stable clock before exit
// - Wait exit delay before DLL-free commands
// - Wait exit plus lock before DLL commands
// - Test enable high 200 ns before select
// - Latency mode lengthens mode-register delays
`include "cmd_timing_consts.svh"
module dram_cmd_device
    import cmd_timing_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    cmd_link_if.device link,
    input wire cmd_timing_pkg::speed_grade_e grade,
    input wire logic persistent_parity,
    input wire logic parity_enable,
    input wire logic cal_mode,
    input wire logic gear_down,
    input wire logic max_power_saving_mode_request,
    output logic cmd_valid,
    output logic [23:0] cmd_ca,
    output logic parity_error,
    output logic cmd_path_off,
    output logic connectivity_test_mode,
    output logic config_error
);
    import cmd_timing_pkg::*;

    typedef enum logic [1:0] {
        ALERT_IDLE,
        ALERT_WAIT,
        ALERT_LOW
    } alert_state_e;

    logic cs_s1, cs_s2, par_s1, par_s2, ten_s1, ten_s2, cke_s1, cke_s2;
    logic [23:0] ca_s1, ca_s2;
    logic cs_prev;
    logic [2:0] cal_cnt, next_cal_cnt;
    logic cal_pend, next_cal_pend;
    logic [2:0] par_lat;
    logic [2:0] cal_lat;
    logic [7:0] pw_min;
    logic take;
    alert_state_e alert_state, next_alert_state;
    logic [7:0] alert_cnt, next_alert_cnt;
    logic check_on, next_check_on;
    logic rearm, next_rearm;
    logic alert_n_q, next_alert_n_q;
    logic perr, next_perr;
    logic v_q, next_v_q;
    logic [23:0] ca_q, next_ca_q;
    logic [7:0] mp_cnt, next_mp_cnt;
    logic mp_pend, next_mp_pend;
    logic off_q, next_off_q;
    logic [7:0] ct_cnt, next_ct_cnt;
    logic ct_q, next_ct_q;
    logic cfg_q, next_cfg_q;

    always_ff @(posedge ref_clk) begin
        cs_s1 <= link.cs_n;
        cs_s2 <= cs_s1;
        ca_s1 <= link.ca;
        ca_s2 <= ca_s1;
        par_s1 <= link.par;
        par_s2 <= par_s1;
        ten_s1 <= link.test_enable_input;
        ten_s2 <= ten_s1;
        cke_s1 <= link.cke;
        cke_s2 <= cke_s1;
    end

    always_comb begin
        par_lat = (grade == GRADE_2400) ? 3'(`PAR_LAT_2400) : 3'(`PAR_LAT_1600);
        case (grade)
            GRADE_1600: begin
                cal_lat = 3'(`CAL_1600);
                pw_min = 8'(`ALERT_PW_MIN_1600);
            end
            GRADE_1866: begin
                cal_lat = 3'(`CAL_1866);
                pw_min = 8'(`ALERT_PW_MIN_1866);
            end
            GRADE_2133: begin
                cal_lat = 3'(`CAL_1866);
                pw_min = 8'(`ALERT_PW_MIN_2133);
            end
            default: begin
                cal_lat = 3'(`CAL_2400);
                pw_min = 8'(`ALERT_PW_MIN_2400);
            end
        endcase
    end

    // Command capture, with optional chip-select-to-command latency
    always_comb begin
        next_cal_cnt = cal_cnt;
        next_cal_pend = cal_pend;
        take = 1'b0;
        if (cal_mode && !gear_down) begin
            if (cs_prev && !cs_s2 && !cal_pend) begin
                next_cal_pend = 1'b1;
                next_cal_cnt = 3'h1;
            end else if (cal_pend) begin
                if (cal_cnt == cal_lat) begin
                    take = 1'b1;
                    next_cal_pend = 1'b0;
                end else begin
                    next_cal_cnt = cal_cnt + 3'h1;
                end
            end
        end else begin
            next_cal_pend = 1'b0;
            take = !cs_s2 && !gear_down ? 1'b1 : !cs_s2;
        end
        if (off_q || ct_q || ten_s2) begin
            take = 1'b0;
        end
        next_v_q = take;
        next_ca_q = take ? ca_s2 : ca_q;
        next_cfg_q = cal_mode && gear_down;
    end

    // Parity check and alert pulse
    always_comb begin
        next_alert_state = alert_state;
        next_alert_cnt = alert_cnt;
        next_check_on = check_on;
        next_alert_n_q = alert_n_q;
        next_perr = 1'b0;
        next_rearm = rearm;
        if (!parity_enable) begin
            next_check_on = 1'b0;
            next_rearm = 1'b0;
        end else if (!rearm && !check_on) begin
            next_check_on = 1'b1;
        end
        case (alert_state)
            ALERT_IDLE: begin
                if (take && check_on && (^{ca_s2, par_s2})) begin
                    next_perr = 1'b1;
                    next_alert_state = ALERT_WAIT;
                    next_alert_cnt = 8'h1;
                    if (!persistent_parity) begin
                        next_check_on = 1'b0;
                        next_rearm = 1'b1;
                    end
                end
            end
            ALERT_WAIT: begin
                if (alert_cnt >= 8'(par_lat)) begin
                    next_alert_state = ALERT_LOW;
                    next_alert_n_q = 1'b0;
                    next_alert_cnt = 8'h1;
                end else begin
                    next_alert_cnt = alert_cnt + 8'h1;
                end
            end
            ALERT_LOW: begin
                if (alert_cnt >= pw_min) begin
                    next_alert_state = ALERT_IDLE;
                    next_alert_n_q = 1'b1;
                    next_alert_cnt = 8'h0;
                end else begin
                    next_alert_cnt = alert_cnt + 8'h1;
                end
            end
            default: begin
                next_alert_state = ALERT_IDLE;
                next_alert_n_q = 1'b1;
            end
        endcase
    end

    // Power saving entry and connectivity test entry
    always_comb begin
        next_mp_cnt = mp_cnt;
        next_mp_pend = mp_pend;
        next_off_q = off_q;
        if (max_power_saving_mode_request && !mp_pend && !off_q) begin
            next_mp_pend = 1'b1;
            next_mp_cnt = 8'h0;
        end else if (mp_pend) begin
            if (mp_cnt >= 8'(`MOD_MIN_CK + `CPDED_MIN_CK) + (cal_mode ? 8'(cal_lat) : 8'h0)) begin
                next_off_q = 1'b1;
                next_mp_pend = 1'b0;
            end else begin
                next_mp_cnt = mp_cnt + 8'h1;
            end
        end else if (off_q && cke_s2 && !max_power_saving_mode_request) begin
            next_off_q = 1'b0;
        end
        next_ct_cnt = ct_cnt;
        next_ct_q = ct_q;
        if (!ten_s2) begin
            next_ct_cnt = 8'h0;
            next_ct_q = 1'b0;
        end else if (!ct_q && cs_s2 && ct_cnt < 8'(`CT_ENABLE_CYC)) begin
            next_ct_cnt = ct_cnt + 8'h1;
        end else if (!ct_q && !cs_s2 && ct_cnt >= 8'(`CT_ENABLE_CYC)) begin
            next_ct_q = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cs_prev <= 1'b1;
            cal_cnt <= 3'h0;
            cal_pend <= 1'b0;
            alert_state <= ALERT_IDLE;
            alert_cnt <= 8'h0;
            check_on <= 1'b0;
            rearm <= 1'b0;
            alert_n_q <= 1'b1;
            perr <= 1'b0;
            v_q <= 1'b0;
            ca_q <= 24'h0;
            mp_cnt <= 8'h0;
            mp_pend <= 1'b0;
            off_q <= 1'b0;
            ct_cnt <= 8'h0;
            ct_q <= 1'b0;
            cfg_q <= 1'b0;
        end else begin
            cs_prev <= cs_s2;
            cal_cnt <= next_cal_cnt;
            cal_pend <= next_cal_pend;
            alert_state <= next_alert_state;
            alert_cnt <= next_alert_cnt;
            check_on <= next_check_on;
            rearm <= next_rearm;
            alert_n_q <= next_alert_n_q;
            perr <= next_perr;
            v_q <= next_v_q;
            ca_q <= next_ca_q;
            mp_cnt <= next_mp_cnt;
            mp_pend <= next_mp_pend;
            off_q <= next_off_q;
            ct_cnt <= next_ct_cnt;
            ct_q <= next_ct_q;
            cfg_q <= next_cfg_q;
        end
    end

    assign link.alert_n = alert_n_q;
    assign cmd_valid = v_q;
    assign cmd_ca = ca_q;
    assign parity_error = perr;
    assign cmd_path_off = off_q;
    assign connectivity_test_mode = ct_q;
    assign config_error = cfg_q;
endmodule

// ### src/dram_cmd_host.sv
// Controller end: issues commands and honours device timing windows
`include "cmd_timing_consts.svh"
module dram_cmd_host
    import cmd_timing_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    cmd_link_if.host link,
    input wire cmd_timing_pkg::speed_grade_e grade,
    input wire logic persistent_parity,
    input wire logic cal_mode,
    input wire logic gear_down,
    input wire logic req_valid,
    input wire cmd_timing_pkg::cmd_kind_e req_kind,
    input wire logic [23:0] req_ca,
    input wire logic req_bad_parity,
    input wire logic max_power_saving_mode_exit,
    input wire logic ct_request,
    output logic req_ready,
    output logic alert_seen
);
    import cmd_timing_pkg::*;

    logic al_s1, al_s2;
    logic cs_q, next_cs_q;
    logic [23:0] ca_q, next_ca_q;
    logic par_q, next_par_q;
    logic ten_q, next_ten_q;
    logic [7:0] ten_cnt, next_ten_cnt;
    logic cke_q, next_cke_q;
    logic clkv_q, next_clkv_q;
    logic rdy_q, next_rdy_q;
    logic seen_q, next_seen_q;
    logic [7:0] hold_cnt, next_hold_cnt;
    logic [7:0] rsp_lim;
    logic [7:0] mod_gap;
    logic in_max_power_saving_mode, next_in_max_power_saving_mode;
    logic [1:0] mp_phase, next_mp_phase;
    logic legal;

    always_ff @(posedge ref_clk) begin
        al_s1 <= link.alert_n;
        al_s2 <= al_s1;
    end

    always_comb begin
        case (grade)
            GRADE_1600: rsp_lim = 8'(`RSP_1600);
            GRADE_1866: rsp_lim = 8'(`RSP_1866);
            GRADE_2133: rsp_lim = 8'(`RSP_2133);
            default: rsp_lim = 8'(`RSP_2400);
        endcase
        mod_gap = 8'(`MOD_MIN_CK) + (cal_mode ? 8'((grade == GRADE_2400) ? `CAL_2400 : `CAL_1866) : 8'h0);
    end

    always_comb begin
        next_cs_q = 1'b1;
        next_ca_q = ca_q;
        next_par_q = par_q;
        next_ten_q = ct_request;
        next_ten_cnt = !ten_q ? 8'h0 : (ten_cnt == 8'hff ? ten_cnt : ten_cnt + 8'h1);
        next_cke_q = cke_q;
        next_clkv_q = 1'b1;
        next_seen_q = seen_q || !al_s2;
        next_hold_cnt = (hold_cnt != 8'h0) ? hold_cnt - 8'h1 : 8'h0;
        next_in_max_power_saving_mode = in_max_power_saving_mode;
        next_mp_phase = mp_phase;
        legal = !(cal_mode && gear_down);
        if (!al_s2 && persistent_parity) begin
            next_hold_cnt = rsp_lim;
        end
        if (in_max_power_saving_mode && max_power_saving_mode_exit && mp_phase == 2'h0) begin
            next_cke_q = 1'b1;
            next_in_max_power_saving_mode = 1'b0;
            next_mp_phase = 2'h1;
            next_hold_cnt = 8'(`XS_MIN_CK);
        end else if (mp_phase == 2'h1 && hold_cnt == 8'h0) begin
            next_mp_phase = 2'h2;
            next_hold_cnt = 8'(`XSDLL_MIN_CK);
        end else if (mp_phase == 2'h2 && hold_cnt == 8'h0) begin
            next_mp_phase = 2'h0;
        end
        next_rdy_q = legal && !in_max_power_saving_mode && !ct_request && hold_cnt == 8'h0 && al_s2 && mp_phase == 2'h0;
        if (mp_phase == 2'h2 && hold_cnt != 8'h0 && req_kind == CMD_DLL_FREE) begin
            next_rdy_q = legal;
        end
        if (req_valid && rdy_q && req_kind != CMD_DESELECT && (mp_phase != 2'h2 || req_kind == CMD_DLL_FREE)) begin
            next_cs_q = 1'b0;
            next_ca_q = req_ca;
            next_par_q = (^req_ca) ^ req_bad_parity;
            next_rdy_q = 1'b0;
            if (req_kind == CMD_MODE_REG) begin
                next_hold_cnt = mod_gap;
            end
            if (req_kind == CMD_MAX_POWER_SAVING_MODE_ENTER) begin
                next_in_max_power_saving_mode = 1'b1;
                next_cke_q = 1'b0;
            end
        end
        if (ct_request && !ten_q) begin
            next_cs_q = 1'b1;
        end else if (ct_request && ten_cnt >= 8'(`CT_ENABLE_CYC)) begin
            next_cs_q = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cs_q <= 1'b1;
            ca_q <= 24'h0;
            par_q <= 1'b0;
            ten_q <= 1'b0;
            ten_cnt <= 8'h0;
            cke_q <= 1'b1;
            clkv_q <= 1'b0;
            rdy_q <= 1'b0;
            seen_q <= 1'b0;
            hold_cnt <= 8'h0;
            in_max_power_saving_mode <= 1'b0;
            mp_phase <= 2'h0;
        end else begin
            cs_q <= next_cs_q;
            ca_q <= next_ca_q;
            par_q <= next_par_q;
            ten_q <= next_ten_q;
            ten_cnt <= next_ten_cnt;
            cke_q <= next_cke_q;
            clkv_q <= next_clkv_q;
            rdy_q <= next_rdy_q;
            seen_q <= next_seen_q;
            hold_cnt <= next_hold_cnt;
            in_max_power_saving_mode <= next_in_max_power_saving_mode;
            mp_phase <= next_mp_phase;
        end
    end

    assign link.cs_n = cs_q;
    assign link.ca = ca_q;
    assign link.par = par_q;
    assign link.test_enable_input = ten_q;
    assign link.cke = cke_q;
    assign link.clk_valid = clkv_q;
    assign req_ready = rdy_q;
    assign alert_seen = seen_q;
endmodule

// ### verification/cmd_link_properties.sv
// Timing checker for the command link between the two ends
module cmd_link_properties (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic [23:0] ca,
    input wire logic par,
    input wire logic alert_n,
    input wire logic cke,
    input wire logic test_enable_input
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BAD_MAX = 16;
    logic [7:0] low_cnt, next_low_cnt, ten_cnt, next_ten_cnt, bad_age, next_bad_age;

    // Alert low time, test enable time, age of last bad command
    always_comb begin
        next_low_cnt = alert_n ? 8'h00 : (low_cnt == 8'hff ? low_cnt : low_cnt + 8'h01);
        next_ten_cnt = (!test_enable_input || !cs_n) ? 8'h00 : (ten_cnt == 8'hff ? ten_cnt : ten_cnt + 8'h01);
        next_bad_age = (!cs_n && ^{ca, par}) ? 8'h00 : (bad_age == 8'hff ? bad_age : bad_age + 8'h01);
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            low_cnt <= 8'h00;
            ten_cnt <= 8'h00;
            bad_age <= 8'hff;
        end else begin
            low_cnt <= next_low_cnt;
            ten_cnt <= next_ten_cnt;
            bad_age <= next_bad_age;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_bad_cmd;
        !cs_n && ^{ca, par} && alert_n && cke && !test_enable_input;
    endsequence
    sequence s_alert_fall;
        $fell(alert_n);
    endsequence

    property p_alert_on_bad;
        s_bad_cmd |-> ##[1:BAD_MAX] !alert_n;
    endproperty
    a_alert_on_bad: assert property (p_alert_on_bad) else $error("alert missing after bad parity");
    property p_alert_cause;
        s_alert_fall |-> bad_age <= 8'h10;
    endproperty
    a_alert_cause: assert property (p_alert_cause) else $error("alert without bad command");
    property p_alert_width_min;
        $rose(alert_n) |-> low_cnt >= 8'h30;
    endproperty
    a_alert_width_min: assert property (p_alert_width_min) else $error("alert pulse too short");
    property p_alert_width_max;
        !alert_n |-> low_cnt < 8'h90;
    endproperty
    a_alert_width_max: assert property (p_alert_width_max) else $error("alert pulse too long");
    property p_rsp_deselect;
        !alert_n && low_cnt >= 8'h40 |-> cs_n;
    endproperty
    a_rsp_deselect: assert property (p_rsp_deselect) else $error("command late in alert window");
    property p_ct_entry;
        test_enable_input && $fell(cs_n) |-> ten_cnt >= 8'h14;
    endproperty
    a_ct_entry: assert property (p_ct_entry) else $error("select low too soon after test enable");
    property p_cmd_single;
        $fell(cs_n) && cke && !test_enable_input |=> cs_n;
    endproperty
    a_cmd_single: assert property (p_cmd_single) else $error("select held low");
    property p_ca_hold;
        cs_n && !test_enable_input && !$past(reset) |-> $stable({ca, par});
    endproperty
    a_ca_hold: assert property (p_ca_hold) else $error("address moved between commands");
endmodule

// ### verification/dram_cmd_parity_latency_timing_bench.sv
// Self-checking bench joining host and device ends
module dram_cmd_parity_latency_timing_bench import cmd_timing_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    speed_grade_e grade = GRADE_1600;
    logic persistent_parity = 1'b0, parity_enable = 1'b1, cal_mode = 1'b0, gear_down = 1'b0, max_power_saving_mode_request = 1'b0;
    logic req_valid = 1'b0, req_bad_parity = 1'b0, max_power_saving_mode_exit = 1'b0, ct_request = 1'b0;
    cmd_kind_e req_kind = CMD_OTHER;
    logic [23:0] req_ca = 24'h000000;
    logic cmd_valid, parity_error, cmd_path_off, connectivity_test_mode, config_error, req_ready, alert_seen;
    logic [23:0] cmd_ca;
    int err_count = 0, comparisons = 0, n, m;
    int pl_t[4] = '{4, 4, 4, 5};
    int pw_t[4] = '{48, 56, 64, 72};
    int cal_t[4] = '{3, 4, 4, 5};

    always #5 ref_clk = ~ref_clk;

    cmd_link_if link();
    dram_cmd_device u_dram_cmd_device (.ref_clk(ref_clk), .reset(reset), .link(link), .grade(grade),
        .persistent_parity(persistent_parity), .parity_enable(parity_enable), .cal_mode(cal_mode),
        .gear_down(gear_down), .max_power_saving_mode_request(max_power_saving_mode_request), .cmd_valid(cmd_valid), .cmd_ca(cmd_ca),
        .parity_error(parity_error), .cmd_path_off(cmd_path_off),
        .connectivity_test_mode(connectivity_test_mode), .config_error(config_error));
    dram_cmd_host u_dram_cmd_host (.ref_clk(ref_clk), .reset(reset), .link(link), .grade(grade),
        .persistent_parity(persistent_parity), .cal_mode(cal_mode), .gear_down(gear_down),
        .req_valid(req_valid), .req_kind(req_kind), .req_ca(req_ca), .req_bad_parity(req_bad_parity),
        .max_power_saving_mode_exit(max_power_saving_mode_exit), .ct_request(ct_request), .req_ready(req_ready), .alert_seen(alert_seen));
    cmd_link_properties u_cmd_link_properties (.ref_clk(ref_clk), .reset(reset), .cs_n(link.cs_n),
        .ca(link.ca), .par(link.par), .alert_n(link.alert_n), .cke(link.cke),
        .test_enable_input(link.test_enable_input));

    task automatic finish_test();
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Watched condition by index
    function automatic logic sel(input int w);
        case (w)
            0: return cmd_valid;
            1: return !link.alert_n;
            2: return link.alert_n;
            3: return req_ready;
            4: return cmd_path_off;
            5: return connectivity_test_mode;
            default: return !link.cs_n;
        endcase
    endfunction

    // Counts falling edges until the condition holds, bounded
    task automatic wait_for(input int w, output int cnt);
        cnt = 0;
        while (sel(w) !== 1'b1) begin
            if (cnt == 400) begin
                err_count++;
                finish_test();
            end
            @(negedge ref_clk);
            cnt++;
        end
    endtask

    task automatic send(input cmd_kind_e k, input logic [23:0] a, input logic b);
        int c;
        wait_for(3, c);
        req_kind = k;
        req_ca = a;
        req_bad_parity = b;
        req_valid = 1'b1;
        // Held until the host shows the select low
        wait_for(6, c);
        req_valid = 1'b0;
    endtask

    task automatic cmd_chk(input cmd_kind_e k, input logic [23:0] a, input logic b, output int d);
        send(k, a, b);
        wait_for(0, d);
        check("cmd_ca", cmd_ca, a);
        check("parity_error", parity_error, b);
    endtask

    initial begin
        repeat (6) @(negedge ref_clk);
        reset = 1'b0;
        check("alert_seen", alert_seen, 24'h0);
        cmd_chk(CMD_DLL_FREE, 24'h000001, 1'b0, n);
        cmd_chk(CMD_DLL_LOCKED, 24'hffffff, 1'b0, n);
        cmd_chk(CMD_OTHER, 24'ha5a5a4, 1'b0, n);
        for (int g = 0; g < 4; g++) begin
            grade = speed_grade_e'(g);
            cmd_chk(CMD_OTHER, 24'h123456, 1'b1, n);
            wait_for(1, n);
            check("parity_latency", n, pl_t[g]);
            wait_for(2, n);
            check("alert_width", n, pw_t[g]);
            check("alert_seen", alert_seen, 24'h1);
            parity_enable = 1'b0;
            @(negedge ref_clk);
            parity_enable = 1'b1;
        end
        persistent_parity = 1'b1;
        repeat (2) begin
            cmd_chk(CMD_DLL_FREE, 24'h0000ff, 1'b1, n);
            wait_for(1, n);
            wait_for(2, n);
        end
        persistent_parity = 1'b0;
        for (int g = 0; g < 4; g += 3) begin
            grade = speed_grade_e'(g);
            cmd_chk(CMD_OTHER, 24'h00000f, 1'b0, n);
            cal_mode = 1'b1;
            cmd_chk(CMD_OTHER, 24'h0000f0, 1'b0, m);
            check("cal_delay", m - n, cal_t[g]);
            send(CMD_MODE_REG, 24'h000300, 1'b0);
            wait_for(3, m);
            check("mode_reg_gap", m + 1 >= 24 + cal_t[g], 24'h1);
            gear_down = 1'b1;
            repeat (4) @(negedge ref_clk);
            check("config_error", config_error, 24'h1);
            gear_down = 1'b0;
            cal_mode = 1'b0;
        end
        for (int k = 0; k < 2; k++) begin
            send(CMD_MAX_POWER_SAVING_MODE_ENTER, 24'h000000, 1'b0);
            max_power_saving_mode_request = 1'b1;
            wait_for(4, n);
            check("path_off_delay", n >= 28, 24'h1);
            check("clk_valid_entry", link.clk_valid, 24'h1);
            req_kind = k ? CMD_DLL_LOCKED : CMD_DLL_FREE;
            req_ca = 24'h000011;
            req_bad_parity = 1'b0;
            max_power_saving_mode_request = 1'b0;
            max_power_saving_mode_exit = 1'b1;
            req_valid = 1'b1;
            wait_for(3, n);
            check("exit_delay", n >= (k ? 94 : 30), 24'h1);
            check("clk_valid_exit", link.clk_valid, 24'h1);
            @(negedge ref_clk);
            req_valid = 1'b0;
            max_power_saving_mode_exit = 1'b0;
            wait_for(0, n);
            check("exit_cmd_ca", cmd_ca, 24'h000011);
            check("cmd_path_off", cmd_path_off, 24'h0);
        end
        ct_request = 1'b1;
        wait_for(5, n);
        check("ct_entry_delay", n >= 20, 24'h1);
        finish_test();
    end
endmodule
